// *** src/smsp_params.svh ***
// Register offsets, field positions, reset values and timing counts of the serial port
`ifndef SMSP_PARAMS_SVH
`define SMSP_PARAMS_SVH
`define SMSP_OFF_CTRL 12'h000
`define SMSP_OFF_STAT 12'h004
`define SMSP_OFF_DATA 12'h008
`define SMSP_OFF_PINS 12'h00C
`define SMSP_CTRL_IRQ_EN 7
`define SMSP_CTRL_PORT_EN 6
`define SMSP_CTRL_LSB_FIRST 5
`define SMSP_CTRL_CONTROLLER 4
`define SMSP_CTRL_CPOL 3
`define SMSP_CTRL_CPHA 2
`define SMSP_STAT_DONE 7
`define SMSP_STAT_WRITE_COLLISION_FLAG 6
`define SMSP_STAT_DOUBLE 0
`define SMSP_PINS_POWER_GATE 0
`define SMSP_PINS_GIE 1
`define SMSP_PINS_MOSI_OUT 2
`define SMSP_PINS_MISO_OUT 3
`define SMSP_PINS_SCK_OUT 4
`define SMSP_PINS_SS_OUT 5
`define SMSP_PINS_SS_LEVEL 6
`define SMSP_PINS_RESET 8'h01
`define SMSP_BITS_PER_BYTE 4'h8
`endif

// *** src/smsp_pkg.sv ***
// Types shared by the serial port files
package smsp_pkg;
   typedef enum logic [1:0] {
      SMSP_IDLE,
      SMSP_LEAD,
      SMSP_TRAIL
   } smsp_ctl_state_t;
endpackage

// *** src/smsp_rx_buffer.sv ***
// Receive buffer holding the last complete byte
`timescale 1ns/1ps
module smsp_rx_buffer
   import smsp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data
);
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data <= 8'h00;
      end else if (wr_en) begin
         rd_data <= wr_data;
      end
   end
endmodule

// *** src/smsp_top.sv ***
// Byte serial port, controller or target role, with an APB register slave
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "smsp_params.svh"

// What this block does
// - Controller role: data write starts clock and shifts eight bits out.
// - After a byte, clock stops, done flag set, interrupt if enabled.
// - Controller does not drive select automatically; software owns it.
// - Last received byte is kept in a receive buffer for software.
// - Target with select high: output released, clock edges ignored.
// - Target with select high accepts data writes and sends them later.
// - Receive is double buffered; software reads before next byte completes.
// - Enabled port forces role inputs (MISO for controller; MOSI, SCK, select for target); output enables follow pins bits.
// - Target select is always input; low select activates output if enabled.
// - Target select high resets bit counter and drops partial byte.
// - Controller with select as output: pin is plain general output.
// - Controller with select as input: low clears controller select.
// - Lost controller role sets done flag, interrupt with both enables.
// - Data shifts out on one clock edge, sampled on the other.
// - Four clock polarity and phase modes with fixed sample edges.
// - Port stays disabled while the power gate bit is one.
// - Controller to target on MOSI, target to controller on MISO.
// - Bit order select one sends LSB first, zero MSB first.
// - Data write during a transfer sets the write collision flag.
// - Controller clock divided from system clock, divide 2 to 128.
// - Clock polarity one idles the clock high, zero idles low.
module smsp_top
   import smsp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe,
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe,
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   input wire logic ss_in,
   output logic ss_out,
   output logic ss_oe,
   output logic irq
);
   // ==========================================================
   // Registers and state
   logic [7:0] ctrl;
   logic [7:0] pins;
   logic double_rate;
   logic done_flag;
   logic write_collision_flag_flag;
   logic stat_seen;
   logic [7:0] shifter;
   logic [3:0] bit_cnt;
   logic [6:0] div_cnt;
   logic busy;
   smsp_ctl_state_t ctl_state;
   logic mosi_s1, mosi_s2, miso_s1, miso_s2, sck_s1, sck_s2, ss_s1, ss_s2;
   logic sck_prev;
   logic [7:0] rx_data;
   logic rx_wr;
   logic [7:0] rx_byte;

   wire transfer_irq_enable = ctrl[`SMSP_CTRL_IRQ_EN];
   wire serial_power_gate = pins[`SMSP_PINS_POWER_GATE];
   wire port_enable = ctrl[`SMSP_CTRL_PORT_EN] & ~serial_power_gate;
   wire bit_order_select = ctrl[`SMSP_CTRL_LSB_FIRST];
   wire controller_select = ctrl[`SMSP_CTRL_CONTROLLER];
   wire cpol = ctrl[`SMSP_CTRL_CPOL];
   wire cpha = ctrl[`SMSP_CTRL_CPHA];
   wire is_ctl = port_enable & controller_select;
   wire is_tgt = port_enable & ~controller_select;

   // ==========================================================
   // APB access decode
   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire rd = acc & ~pwrite;
   wire hit_ctrl = paddr == `SMSP_OFF_CTRL;
   wire hit_stat = paddr == `SMSP_OFF_STAT;
   wire hit_data = paddr == `SMSP_OFF_DATA;
   wire hit_pins = paddr == `SMSP_OFF_PINS;
   wire mapped = hit_ctrl | hit_stat | hit_data | hit_pins;
   wire data_wr = wr & hit_data;
   wire data_acc = acc & hit_data;

   // ==========================================================
   // Input synchronisers
   always_ff @(posedge clk) begin
      if (rst) begin
         {mosi_s1, mosi_s2, miso_s1, miso_s2} <= 4'h0;
         {sck_s1, sck_s2} <= 2'h0;
         {ss_s1, ss_s2} <= 2'h3;
      end else begin
         mosi_s1 <= mosi_in;
         mosi_s2 <= mosi_s1;
         miso_s1 <= miso_in;
         miso_s2 <= miso_s1;
         sck_s1 <= sck_in;
         sck_s2 <= sck_s1;
         ss_s1 <= ss_in;
         ss_s2 <= ss_s1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sck_prev <= 1'b0;
      end else begin
         sck_prev <= sck_s2;
      end
   end

   // Edges of the incoming clock, valid only while selected as target
   wire tgt_sel = is_tgt & ~ss_s2;
   wire sck_rise = sck_s2 & ~sck_prev;
   wire sck_fall = ~sck_s2 & sck_prev;
   wire tgt_lead = tgt_sel & (cpol ? sck_fall : sck_rise);
   wire tgt_trail = tgt_sel & (cpol ? sck_rise : sck_fall);
   // Controller role lost to an external select
   wire mode_fault = is_ctl & ~pins[`SMSP_PINS_SS_OUT] & ~ss_s2;

   // ==========================================================
   // Controller clock divider: half period in system cycles
   logic [6:0] half_period;
   always_comb begin
      case ({double_rate, ctrl[1:0]})
         3'b000: half_period = 7'h02;
         3'b001: half_period = 7'h08;
         3'b010: half_period = 7'h20;
         3'b011: half_period = 7'h40;
         3'b100: half_period = 7'h01;
         3'b101: half_period = 7'h04;
         3'b110: half_period = 7'h10;
         default: half_period = 7'h20;
      endcase
   end
   wire div_tick = div_cnt == half_period - 7'h01;

   // ==========================================================
   // Shift engine for both roles
   wire in_bit = is_ctl ? miso_s2 : mosi_s2;
   wire out_bit = bit_order_select ? shifter[0] : shifter[7];
   wire ctl_sample = (ctl_state == SMSP_LEAD) & div_tick & ~cpha | (ctl_state == SMSP_TRAIL) & div_tick & cpha;
   wire ctl_setup = (ctl_state == SMSP_TRAIL) & div_tick & ~cpha | (ctl_state == SMSP_LEAD) & div_tick & cpha;
   wire sample = ctl_sample | (tgt_sel & (cpha ? tgt_trail : tgt_lead));
   wire setup = ctl_setup | (tgt_sel & (cpha ? tgt_lead : tgt_trail));
   wire last_sample = sample & (bit_cnt == `SMSP_BITS_PER_BYTE - 4'h1);
   // With trailing-edge sampling the eighth sample falls in the last trailing phase
   wire ctl_last = cpha ? (bit_cnt == `SMSP_BITS_PER_BYTE - 4'h1) : (bit_cnt == `SMSP_BITS_PER_BYTE);
   wire byte_done = is_ctl ? (ctl_state == SMSP_TRAIL) & div_tick & ctl_last
                           : last_sample;
   wire [7:0] captured = bit_order_select ? {in_bit, shifter[7:1]} : {shifter[6:0], in_bit};

   always_ff @(posedge clk) begin
      if (rst) begin
         ctl_state <= SMSP_IDLE;
         div_cnt <= 7'h00;
      end else if (!is_ctl || mode_fault) begin
         ctl_state <= SMSP_IDLE;
         div_cnt <= 7'h00;
      end else begin
         div_cnt <= (ctl_state == SMSP_IDLE || div_tick) ? 7'h00 : div_cnt + 7'h01;
         case (ctl_state)
            SMSP_IDLE: begin
               if (data_wr) begin
                  ctl_state <= SMSP_LEAD;
               end
            end
            SMSP_LEAD: begin
               if (div_tick) begin
                  ctl_state <= SMSP_TRAIL;
               end
            end
            SMSP_TRAIL: begin
               if (div_tick) begin
                  ctl_state <= ctl_last ? SMSP_IDLE : SMSP_LEAD;
               end
            end
            default: ctl_state <= SMSP_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         shifter <= 8'h00;
         bit_cnt <= 4'h0;
         busy <= 1'b0;
      end else if (data_wr && !busy) begin
         shifter <= pwdata[7:0];
         bit_cnt <= 4'h0;
         busy <= is_ctl;
      end else if (is_tgt && ss_s2) begin
         bit_cnt <= 4'h0;
         busy <= 1'b0;
      end else if (!port_enable || mode_fault) begin
         bit_cnt <= 4'h0;
         busy <= 1'b0;
      end else begin
         if (sample) begin
            shifter <= captured;
            bit_cnt <= last_sample && !is_ctl ? 4'h0 : bit_cnt + 4'h1;
            busy <= is_ctl | ~last_sample;
         end else if (setup && bit_cnt != 4'h0 && !is_ctl) begin
            busy <= 1'b1;
         end
         if (is_ctl && byte_done) begin
            busy <= 1'b0;
         end
      end
   end

   assign rx_wr = sample & (bit_cnt == `SMSP_BITS_PER_BYTE - 4'h1);
   assign rx_data = captured;

   smsp_rx_buffer u_rx (
      .clk(clk),
      .rst(rst),
      .wr_en(rx_wr),
      .wr_data(rx_data),
      .rd_data(rx_byte)
   );

   // ==========================================================
   // Control and status registers
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl <= 8'h00;
      end else if (wr && hit_ctrl) begin
         ctrl <= pwdata[7:0];
      end else if (mode_fault) begin
         ctrl[`SMSP_CTRL_CONTROLLER] <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pins <= `SMSP_PINS_RESET;
         double_rate <= 1'b0;
      end else begin
         if (wr && hit_pins) begin
            pins <= pwdata[7:0];
         end
         if (wr && hit_stat) begin
            double_rate <= pwdata[`SMSP_STAT_DOUBLE];
         end
      end
   end

   // Flags clear on a data access after a status read saw them; a new event wins
   always_ff @(posedge clk) begin
      if (rst) begin
         done_flag <= 1'b0;
         write_collision_flag_flag <= 1'b0;
         stat_seen <= 1'b0;
      end else begin
         if (rd && hit_stat) begin
            stat_seen <= done_flag | write_collision_flag_flag;
         end else if (data_acc) begin
            stat_seen <= 1'b0;
         end
         if (byte_done || mode_fault) begin
            done_flag <= 1'b1;
         end else if (data_acc && stat_seen) begin
            done_flag <= 1'b0;
         end
         if (data_wr && busy) begin
            write_collision_flag_flag <= 1'b1;
         end else if (data_acc && stat_seen) begin
            write_collision_flag_flag <= 1'b0;
         end
      end
   end

   // ==========================================================
   // APB read and handshake
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         prdata <= 32'h0000_0000;
         if (psel && !penable && !pwrite) begin
            if (hit_ctrl) begin
               prdata <= {24'h00_0000, ctrl};
            end else if (hit_stat) begin
               prdata <= {24'h00_0000, done_flag, write_collision_flag_flag, 5'h00, double_rate};
            end else if (hit_data) begin
               prdata <= {24'h00_0000, rx_byte};
            end else if (hit_pins) begin
               prdata <= {23'h00_0000, ss_s2, pins};
            end
         end
      end
   end

   // ==========================================================
   // Pin drive and interrupt
   always_ff @(posedge clk) begin
      if (rst) begin
         sck_out <= 1'b0;
         mosi_out <= 1'b0;
         miso_out <= 1'b0;
         ss_out <= 1'b1;
         {mosi_oe, miso_oe, sck_oe, ss_oe} <= 4'h0;
         irq <= 1'b0;
      end else begin
         sck_out <= (ctl_state == SMSP_LEAD) ? ~cpol : cpol;
         if (setup || (ctl_state == SMSP_IDLE && data_wr && !cpha)) begin
            mosi_out <= data_wr && ctl_state == SMSP_IDLE ?
                        (bit_order_select ? pwdata[0] : pwdata[7]) : out_bit;
         end
         if (setup || (tgt_sel && bit_cnt == 4'h0 && !cpha)) begin
            miso_out <= out_bit;
         end
         ss_out <= pins[`SMSP_PINS_SS_LEVEL];
         mosi_oe <= is_tgt ? 1'b0 : pins[`SMSP_PINS_MOSI_OUT];
         sck_oe <= is_tgt ? 1'b0 : pins[`SMSP_PINS_SCK_OUT];
         ss_oe <= is_tgt ? 1'b0 : pins[`SMSP_PINS_SS_OUT];
         miso_oe <= is_ctl ? 1'b0 : (is_tgt ? tgt_sel & pins[`SMSP_PINS_MISO_OUT] : pins[`SMSP_PINS_MISO_OUT]);
         irq <= done_flag & transfer_irq_enable & pins[`SMSP_PINS_GIE];
      end
   end
endmodule

// *** verification/smsp_chk.sv ***
// Assertion checker for the serial port top
`timescale 1ns/1ps
module smsp_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic mosi_oe,
   input wire logic miso_oe,
   input wire logic sck_out,
   input wire logic sck_oe,
   input wire logic ss_in,
   input wire logic ss_oe,
   input wire logic irq
);
   logic [3:0] hi_cnt;
   logic [3:0] lo_cnt;
   default clocking dc @(posedge clk); endclocking
   default disable iff (rst);
   // ====================
   // Steady select level counters
   always_ff @(posedge clk) begin
      if (rst || !ss_in) hi_cnt <= 4'h0;
      else if (hi_cnt != 4'hF) hi_cnt <= hi_cnt + 4'h1;
   end
   always_ff @(posedge clk) begin
      if (rst || ss_in) lo_cnt <= 4'h0;
      else if (lo_cnt != 4'hF) lo_cnt <= lo_cnt + 4'h1;
   end
   // ====================
   // Properties
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_ss_lost;
      (lo_cnt > 4'h5 && !ss_oe) [*6];
   endsequence
   apb_ready_a: assert property (s_setup |=> pready) else $error("pready missing");
   ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
   err_map_a: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h00C))
      else $error("pslverr wrong");
   err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
   miso_release_a: assert property (hi_cnt > 4'h5 |-> !miso_oe) else $error("miso driven");
   role_lost_a: assert property (s_ss_lost |-> !sck_oe && !mosi_oe) else $error("pins driven");
   dir_split_a: assert property (!(mosi_oe && miso_oe)) else $error("both data pins out");
   clock_stop_a: assert property ($rose(irq) |-> ##2 $stable(sck_out) [*4]) else $error("clock runs");
   reset_quiet_a: assert property (disable iff (1'b0) rst |=> !pready && !irq && !sck_oe && !miso_oe)
      else $error("not quiet in reset");
endmodule
bind smsp_top smsp_chk smsp_chk_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr),
   .pready(pready), .pslverr(pslverr), .mosi_oe(mosi_oe), .miso_oe(miso_oe), .sck_out(sck_out),
   .sck_oe(sck_oe), .ss_in(ss_in), .ss_oe(ss_oe), .irq(irq));

// *** verification/smsp_far_model.sv ***
// Far-side serial target answering the controller
`timescale 1ns/1ps
module smsp_far_model (
   input wire logic sck,
   input wire logic ss_n,
   input wire logic mosi,
   input wire logic cpol,
   input wire logic cpha,
   input wire logic [7:0] tx_byte,
   output logic miso,
   output logic [7:0] rx_byte
);
   logic [7:0] sh;
   initial begin
      miso = 1'b0;
      rx_byte = 8'h00;
      sh = 8'h00;
   end
   // ====================
   // Load on select, released line shows the inverse
   always @(ss_n) begin
      if (!ss_n) begin
         sh = tx_byte;
         if (!cpha) miso = sh[7];
      end else begin
         miso = ~miso;
      end
   end
   // ====================
   // Sample and setup on opposite edges
   always @(sck) begin
      if (!ss_n && (sck ^ cpol ^ cpha)) begin
         rx_byte = {rx_byte[6:0], mosi};
      end else if (!ss_n) begin
         if (!cpha) sh = sh << 1;
         miso = sh[7];
         if (cpha) sh = sh << 1;
      end
   end
endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the serial port top
`timescale 1ns/1ps
module testbench;
   typedef struct {logic [11:0] a; logic [31:0] x; logic er;} smsp_row_t;
   typedef struct {logic [7:0] c; logic [7:0] m; logic [7:0] d;} smsp_xfer_t;
   smsp_row_t rows [5] = '{'{12'h000, 32'h0, 1'b0}, '{12'h004, 32'h0, 1'b0}, '{12'h00C, 32'h101, 1'b0},
      '{12'h010, 32'h0, 1'b1}, '{12'hFFC, 32'h0, 1'b1}};
   smsp_xfer_t xf [5] = '{'{8'hD0, 8'hB4, 8'h6A}, '{8'hD5, 8'hB4, 8'h6A}, '{8'hDA, 8'hB4, 8'h6A},
      '{8'hDF, 8'hB4, 8'h6A}, '{8'hF0, 8'h2D, 8'h56}};
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, mosi_out, mosi_oe, miso_out, miso_oe, sck_out, sck_oe, ss_out, ss_oe, irq;
   logic tb_ss = 1'b1, tb_sck = 1'b0, tb_mosi = 1'b0, m_cpol = 1'b0, m_cpha = 1'b0, m_miso;
   logic [7:0] m_tx = 8'h00, m_rx, got;
   wire logic ss_w = ss_oe ? ss_out : tb_ss;
   wire logic sck_w = sck_oe ? sck_out : tb_sck;
   wire logic mosi_w = mosi_oe ? mosi_out : tb_mosi;
   wire logic miso_w = miso_oe ? miso_out : m_miso;
   int err_count = 0, samples_checked = 0, cyc = 0;
   always #5 clk = ~clk;
   smsp_top smsp_top_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mosi_in(mosi_w), .mosi_out(mosi_out),
      .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe), .sck_in(sck_w),
      .sck_out(sck_out), .sck_oe(sck_oe), .ss_in(ss_w), .ss_out(ss_out), .ss_oe(ss_oe), .irq(irq));
   smsp_far_model smsp_far_model_inst (.sck(sck_w), .ss_n(ss_w), .mosi(mosi_w), .cpol(m_cpol), .cpha(m_cpha),
      .tx_byte(m_tx), .miso(m_miso), .rx_byte(m_rx));
   // ====================
   // Tasks
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      samples_checked++;
      if (g !== x) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", nm, x, g);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
      q = prdata;
      e = pslverr;
      if (n >= 50) err_count++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), x, q);
   endtask
   task automatic wait_irq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      chk("irq", 32'h1, irq);
   endtask
   task automatic tgt(input logic [7:0] b, input int nb);
      tb_ss <= 1'b0;
      repeat (6) @(posedge clk);
      for (int k = 7; k > 7 - nb; k--) begin
         tb_mosi <= b[k];
         repeat (5) @(posedge clk);
         got[k] = miso_w;
         tb_sck <= 1'b1;
         repeat (5) @(posedge clk);
         tb_sck <= 1'b0;
      end
      repeat (5) @(posedge clk);
      tb_ss <= 1'b1;
      repeat (6) @(posedge clk);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_count++;
         tally_and_finish();
      end
   end
   // ====================
   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         apb(1'b0, rows[i].a, 32'h0);
         chk("reset read", rows[i].x, q);
         chk("slave error", rows[i].er, e);
      end
      wr(12'h000, 32'hD0);
      wr(12'h008, 32'h11);
      repeat (40) @(posedge clk);
      chk("gated clock", 32'h0, sck_oe);
      foreach (xf[i]) begin
         m_cpol <= xf[i].c[3];
         m_cpha <= xf[i].c[2];
         tb_sck <= xf[i].c[3];
         m_tx <= 8'h6A;
         wr(12'h000, {24'h0, xf[i].c});
         wr(12'h00C, 32'h76);
         wr(12'h00C, 32'h36);
         wr(12'h008, 32'hB4);
         if (i == 3) wr(12'h008, 32'hFF);
         wait_irq();
         chk("far rx", xf[i].m, m_rx);
         rd(12'h004, i == 3 ? 32'hC0 : 32'h80);
         rd(12'h008, xf[i].d);
         rd(12'h004, 32'h0);
         chk("irq", 32'h0, irq);
         wr(12'h00C, 32'h76);
      end
      $display("controller transfers done");
      tb_ss <= 1'b0;
      wr(12'h00C, 32'h16);
      wait_irq();
      rd(12'h000, 32'hE0);
      chk("mosi enable", 32'h0, mosi_oe);
      rd(12'h004, 32'h80);
      apb(1'b0, 12'h008, 32'h0);
      tb_ss <= 1'b1;
      wr(12'h000, 32'hD0);
      rd(12'h000, 32'hD0);
      $display("role loss done");
      wr(12'h000, 32'h40);
      wr(12'h00C, 32'h08);
      wr(12'h008, 32'hC3);
      tgt(8'h5A, 8);
      chk("target tx", 32'hC3, got);
      chk("miso enable", 32'h0, miso_oe);
      rd(12'h004, 32'h80);
      rd(12'h008, 32'h5A);
      tgt(8'hFF, 3);
      rd(12'h004, 32'h0);
      tgt(8'h96, 8);
      rd(12'h004, 32'h80);
      rd(12'h008, 32'h96);
      $display("target transfers done");
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(12'h000, 32'h0);
      rd(12'h00C, 32'h101);
      $display("mid-run reset done");
      tally_and_finish();
   end
endmodule
